// file: hdl/dmt_pkg.sv
// Operation
// [R01] Compare value from high and low bytes
// [R02] Both compare bytes reset to all ones
// [R03] 16-bit mode compares full value, flags high
// [R04] 8-bit mode compares each half separately
// [R05] 16-bit match inverts high toggle output
// [R06] 8-bit matches invert their own outputs
// [R07] Control register write-only, resets to zero
// [R08] Control bit 7 forces high output level
// [R09] Control bit 3 forces low output level
// [R10] Bits 6..4 select high counter input
// [R11] Bits 2..0 select low counter input
// [R12] Event pin counts selected edge polarity
// [R13] Software avoids pin function switch while low
// [R14] Status flags cleared only by written zero
// [R15] Bit 7 set on high counter rollover
// [R16] Bit 6 set on high compare match
// [R17] Flag clears only after being read one
// [R18] Bit 5 enables high overflow interrupt
// [R19] Bit 4 clears counter on high match
// [R20] Bit 3 set on low counter rollover
// [R21] Bit 2 set on low compare match
// [R22] Bit 1 low overflow enable, bit 0 clear
// [R23] 16-bit compare write high first via temp
// [R24] Compare reads return bytes directly
// [R25] Match raised when counter leaves matching value
// [R26] Low compare write suppresses coincident match
// [R27] 16-bit high flag needs all sixteen bits
package dmt_pkg;

    // Register offsets on the byte bus
    localparam logic [3:0] ADDR_TIMER_CONTROL        = 4'h6;
    localparam logic [3:0] ADDR_TIMER_CONTROL_STATUS = 4'h7;
    localparam logic [3:0] ADDR_COUNTER_HIGH         = 4'h8;
    localparam logic [3:0] ADDR_COUNTER_LOW          = 4'h9;
    localparam logic [3:0] ADDR_COMPARE_VALUE_HIGH   = 4'ha;
    localparam logic [3:0] ADDR_COMPARE_VALUE_LOW    = 4'hb;

    // Values after reset, the refused-read value and the counter maximum
    localparam logic [7:0] COMPARE_RESET = 8'hff;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET  = 8'h00;
    localparam logic [7:0] COUNTER_RESET = 8'h00;
    localparam logic [7:0] READ_NONE     = 8'hff;
    localparam logic [7:0] COUNT_MAX     = 8'hff;

    // Status field positions
    localparam int BIT_OVERFLOW_FLAG_HIGH = 7;
    localparam int BIT_MATCH_FLAG_HIGH    = 6;
    localparam int BIT_OVERFLOW_FLAG_LOW  = 3;
    localparam int BIT_MATCH_FLAG_LOW     = 2;
    localparam logic [7:0] STATUS_FLAG_MASK = 8'hcc;

    // Control field positions
    localparam int BIT_OUT_LEVEL_HIGH = 7;
    localparam int BIT_OUT_LEVEL_LOW  = 3;

    // Prescaler taps: system clock over 32, 16, 4, 2
    localparam int         PRESCALE_WIDTH = 5;
    localparam logic [4:0] MASK_DIV32     = 5'h1f;
    localparam logic [4:0] MASK_DIV16     = 5'h0f;
    localparam logic [4:0] MASK_DIV4      = 5'h03;
    localparam logic [4:0] MASK_DIV2      = 5'h01;

    // Clock and event pin timing
    localparam int CLK_PERIOD_PS        = 5000;
    localparam int EVENT_MIN_WIDTH_PS   = 10000;
    localparam int EVENT_MIN_WIDTH_CYC  = (EVENT_MIN_WIDTH_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    typedef struct packed {
        logic out_level_high;
        logic high_clk_sel_top;
        logic high_clk_sel_mid;
        logic high_clk_sel_bottom;
        logic out_level_low;
        logic low_clk_sel_top;
        logic low_clk_sel_mid;
        logic low_clk_sel_bottom;
    } dmt_ctrl_s;

    typedef struct packed {
        logic overflow_flag_high;
        logic match_flag_high;
        logic overflow_irq_en_high;
        logic clear_on_match_high;
        logic overflow_flag_low;
        logic match_flag_low;
        logic overflow_irq_en_low;
        logic clear_on_match_low;
    } dmt_status_s;

endpackage

// file: hdl/dmt_prescaler.sv
`timescale 1ns/10ps
module dmt_prescaler
    import dmt_pkg::*;
#(
    parameter int WIDTH = PRESCALE_WIDTH
)
(
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    input  wire logic [1:0] i_sel,
    output logic            o_tick
);

    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;
    logic [WIDTH-1:0] mask;
    logic             next_tick;

    // Free divider, one-cycle tick at the chosen rate
    always_comb
    begin
        next_count = count + WIDTH'(1);
        case (i_sel)
            2'h0:    mask = WIDTH'(MASK_DIV32);
            2'h1:    mask = WIDTH'(MASK_DIV16);
            2'h2:    mask = WIDTH'(MASK_DIV4);
            default: mask = WIDTH'(MASK_DIV2);
        endcase
        next_tick = ((count & mask) == mask);
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            count  <= '0;
            o_tick <= 1'b0;
        end
        else
        begin
            count  <= next_count;
            o_tick <= next_tick;
        end
    end

endmodule // dmt_prescaler

// file: hdl/dmt_timer.sv
`timescale 1ns/10ps
module dmt_timer
    import dmt_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    input  wire logic [3:0] i_addr,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    input  wire logic [7:0] i_wdata,
    output logic      [7:0] o_rdata,
    input  wire logic       i_event_in_pin,
    input  wire logic       i_event_edge_sel,
    output logic            o_toggle_out_high,
    output logic            o_toggle_out_low,
    output logic            o_irq_req_high,
    output logic            o_irq_req_low
);

    dmt_ctrl_s   ctrl;
    dmt_ctrl_s   next_ctrl;
    dmt_status_s status;
    dmt_status_s next_status;
    logic [7:0]  seen;
    logic [7:0]  next_seen;
    logic [7:0]  compare_value_high;
    logic [7:0]  next_compare_value_high;
    logic [7:0]  compare_value_low;
    logic [7:0]  next_compare_value_low;
    logic [7:0]  counter_high;
    logic [7:0]  next_counter_high;
    logic [7:0]  counter_low;
    logic [7:0]  next_counter_low;
    logic [7:0]  temp;
    logic [7:0]  next_temp;
    logic [7:0]  next_rdata;
    logic        next_toggle_high;
    logic        next_toggle_low;
    logic        next_irq_high;
    logic        next_irq_low;
    logic [2:0]  event_sync;
    logic        presc_tick_high;
    logic        presc_tick_low;
    logic        mode16;
    logic        event_edge;
    logic        tick_low;
    logic        tick_high;
    logic        wr_ctrl;
    logic        wr_status;
    logic        wr_cnt_high;
    logic        wr_cnt_low;
    logic        wr_cmp_high;
    logic        wr_cmp_low;
    logic        rd_status;
    logic        rd_cnt_high;
    logic        equal_low;
    logic        equal_high;
    logic        match_low_evt;
    logic        match_high_evt;
    logic        match_wide_evt;
    logic        ovf_low_evt;
    logic        ovf_high_evt;
    logic        clear_low;
    logic        clear_high;
    logic [7:0]  st;
    logic [7:0]  sets;
    logic [7:0]  clears;

    // Prescaled taps for each half
    dmt_prescaler #(.WIDTH(PRESCALE_WIDTH)) u_presc_high (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_sel   ({ctrl.high_clk_sel_mid, ctrl.high_clk_sel_bottom}),
        .o_tick  (presc_tick_high)
    );

    dmt_prescaler #(.WIDTH(PRESCALE_WIDTH)) u_presc_low (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_sel   ({ctrl.low_clk_sel_mid, ctrl.low_clk_sel_bottom}),
        .o_tick  (presc_tick_low)
    );

    // Event pin synchroniser plus one stage for edge detection
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            event_sync <= 3'h0;
        else
            event_sync <= {event_sync[1:0], i_event_in_pin};
    end

    // Bus decode and counting events
    always_comb
    begin
        mode16      = !ctrl.high_clk_sel_top;
        wr_ctrl     = i_wr && (i_addr == ADDR_TIMER_CONTROL);
        wr_status   = i_wr && (i_addr == ADDR_TIMER_CONTROL_STATUS);
        wr_cnt_high = i_wr && (i_addr == ADDR_COUNTER_HIGH);
        wr_cnt_low  = i_wr && (i_addr == ADDR_COUNTER_LOW);
        wr_cmp_high = i_wr && (i_addr == ADDR_COMPARE_VALUE_HIGH);
        wr_cmp_low  = i_wr && (i_addr == ADDR_COMPARE_VALUE_LOW);
        rd_status   = i_rd && (i_addr == ADDR_TIMER_CONTROL_STATUS);
        rd_cnt_high = i_rd && (i_addr == ADDR_COUNTER_HIGH);
        // Edge polarity picked outside the block
        event_edge = i_event_edge_sel ? (event_sync[1] && !event_sync[2])  // R12
                                      : (!event_sync[1] && event_sync[2]);
        tick_low   = ctrl.low_clk_sel_top ? presc_tick_low : event_edge;  // R11
        tick_high  = mode16 ? (tick_low && (counter_low == COUNT_MAX))    // R10
                            : presc_tick_high;
        equal_low  = (counter_low == compare_value_low);
        equal_high = (counter_high == compare_value_high);
        // Match fires on the tick that leaves the equal value
        match_low_evt  = tick_low && equal_low && !wr_cmp_low;             // R25 R26 R04
        match_wide_evt = mode16 && match_low_evt && equal_high;            // R03 R27
        match_high_evt = mode16 ? match_wide_evt
                                : (tick_high && equal_high);               // R04
        ovf_low_evt    = tick_low && (counter_low == COUNT_MAX);
        ovf_high_evt   = tick_high && (counter_high == COUNT_MAX);
        clear_high     = match_high_evt && status.clear_on_match_high;    // R19
        clear_low      = mode16 ? clear_high
                                : (match_low_evt && status.clear_on_match_low);  // R22
    end

    // Next state of registers, counter and outputs
    always_comb
    begin
        next_ctrl               = ctrl;
        next_compare_value_high = compare_value_high;
        next_compare_value_low  = compare_value_low;
        next_counter_high       = counter_high;
        next_counter_low        = counter_low;
        next_temp               = temp;
        next_rdata              = o_rdata;
        st                      = status;
        sets                    = 8'h00;
        clears                  = 8'h00;

        // Counting, clear on match wins over increment
        if (tick_low)
            next_counter_low = clear_low ? COUNTER_RESET : counter_low + 8'h01;
        if (tick_high)
            next_counter_high = counter_high + 8'h01;
        if (clear_high)
            next_counter_high = COUNTER_RESET;                             // R19

        // Control writes
        if (wr_ctrl)
            next_ctrl = dmt_ctrl_s'(i_wdata);                              // R07

        // Compare writes: high byte parked in temp in 16-bit mode
        if (wr_cmp_high)
        begin
            if (mode16)
                next_temp = i_wdata;                                       // R23
            else
                next_compare_value_high = i_wdata;                         // R01
        end
        if (wr_cmp_low)
        begin
            next_compare_value_low = i_wdata;                              // R01
            if (mode16)
                next_compare_value_high = temp;                            // R23
        end

        // Counter writes follow the same byte pairing
        if (wr_cnt_high)
        begin
            if (mode16)
                next_temp = i_wdata;
            else
                next_counter_high = i_wdata;
        end
        if (wr_cnt_low)
        begin
            next_counter_low = i_wdata;
            if (mode16)
                next_counter_high = temp;
        end
        if (rd_cnt_high && mode16)
            next_temp = counter_low;

        // Status: enables written, flags cleared by zero after a read of one
        if (wr_status)
        begin
            st     = (st & STATUS_FLAG_MASK) | (i_wdata & ~STATUS_FLAG_MASK);  // R18 R22
            clears = ~i_wdata & seen & STATUS_FLAG_MASK;                   // R14 R17
        end
        sets[BIT_OVERFLOW_FLAG_HIGH] = ovf_high_evt;                       // R15
        sets[BIT_MATCH_FLAG_HIGH]    = match_high_evt;                     // R16
        sets[BIT_OVERFLOW_FLAG_LOW]  = ovf_low_evt;                        // R20
        sets[BIT_MATCH_FLAG_LOW]     = match_low_evt;                      // R21
        // Hardware set beats a coincident clear
        next_status = dmt_status_s'((st & ~clears) | sets);
        next_seen   = seen & ~clears;
        if (rd_status)
            next_seen = status & STATUS_FLAG_MASK;                         // R17

        // Read data, compare bytes read directly
        if (i_rd)
        begin
            case (i_addr)
                ADDR_TIMER_CONTROL_STATUS: next_rdata = status;
                ADDR_COUNTER_HIGH:         next_rdata = counter_high;
                ADDR_COUNTER_LOW:          next_rdata = mode16 ? temp : counter_low;
                ADDR_COMPARE_VALUE_HIGH:   next_rdata = compare_value_high;  // R24
                ADDR_COMPARE_VALUE_LOW:    next_rdata = compare_value_low;   // R24
                default:                   next_rdata = READ_NONE;
            endcase
        end

        // Toggle outputs, a control write wins over a match
        next_toggle_high = o_toggle_out_high ^ match_high_evt;             // R05 R06
        next_toggle_low  = o_toggle_out_low ^ match_low_evt;               // R06
        if (wr_ctrl)
        begin
            next_toggle_high = i_wdata[BIT_OUT_LEVEL_HIGH];                // R08
            next_toggle_low  = i_wdata[BIT_OUT_LEVEL_LOW];                 // R09
        end

        // Interrupt request pulses toward the interrupt controller
        next_irq_high = match_high_evt || (ovf_high_evt && status.overflow_irq_en_high);  // R03 R18
        next_irq_low  = match_low_evt || (ovf_low_evt && status.overflow_irq_en_low);     // R04 R22
    end

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            ctrl               <= dmt_ctrl_s'(CONTROL_RESET);
            status             <= dmt_status_s'(STATUS_RESET);
            seen               <= 8'h00;
            compare_value_high <= COMPARE_RESET;                           // R02
            compare_value_low  <= COMPARE_RESET;                           // R02
            counter_high       <= COUNTER_RESET;
            counter_low        <= COUNTER_RESET;
            temp               <= 8'h00;
            o_rdata            <= 8'h00;
            o_toggle_out_high  <= 1'b0;
            o_toggle_out_low   <= 1'b0;
            o_irq_req_high     <= 1'b0;
            o_irq_req_low      <= 1'b0;
        end
        else
        begin
            ctrl               <= next_ctrl;
            status             <= next_status;
            seen               <= next_seen;
            compare_value_high <= next_compare_value_high;
            compare_value_low  <= next_compare_value_low;
            counter_high       <= next_counter_high;
            counter_low        <= next_counter_low;
            temp               <= next_temp;
            o_rdata            <= next_rdata;
            o_toggle_out_high  <= next_toggle_high;
            o_toggle_out_low   <= next_toggle_low;
            o_irq_req_high     <= next_irq_high;
            o_irq_req_low      <= next_irq_low;
        end
    end

    // Checks
    property p_compare_reset;
        @(posedge i_clk) disable iff (i_reset)
        $past(i_reset) |-> (compare_value_high == 8'hff) && (compare_value_low == 8'hff);
    endproperty
    a_compare_reset: assert property (p_compare_reset)  // R02
        else $error("compare bytes not all ones after reset");

    property p_control_reset;
        @(posedge i_clk) disable iff (i_reset)
        $past(i_reset) |-> (ctrl == dmt_ctrl_s'(8'h00)) && !o_toggle_out_high && !o_toggle_out_low;
    endproperty
    a_control_reset: assert property (p_control_reset)  // R07
        else $error("control not zero after reset");

    property p_level_high;
        @(posedge i_clk) disable iff (i_reset)
        wr_ctrl |=> (o_toggle_out_high == $past(i_wdata[7]));
    endproperty
    a_level_high: assert property (p_level_high)  // R08
        else $error("high output level not taken from control write");

    property p_level_low;
        @(posedge i_clk) disable iff (i_reset)
        wr_ctrl |=> (o_toggle_out_low == $past(i_wdata[3]));
    endproperty
    a_level_low: assert property (p_level_low)  // R09
        else $error("low output level not taken from control write");

    property p_toggle_wide;
        @(posedge i_clk) disable iff (i_reset)
        (match_wide_evt && !wr_ctrl) |=> (o_toggle_out_high != $past(o_toggle_out_high)) && o_irq_req_high;
    endproperty
    a_toggle_wide: assert property (p_toggle_wide)  // R05
        else $error("high toggle output did not invert on wide match");

    property p_overflow_high_cause;
        @(posedge i_clk) disable iff (i_reset)
        $rose(status.overflow_flag_high) |-> $past(tick_high && (counter_high == 8'hff));
    endproperty
    a_overflow_high_cause: assert property (p_overflow_high_cause)  // R15
        else $error("high overflow flag set without rollover");

    property p_match_low_clear;
        @(posedge i_clk) disable iff (i_reset)
        $fell(status.match_flag_low) |-> $past(wr_status && !i_wdata[2] && seen[2]);
    endproperty
    a_match_low_clear: assert property (p_match_low_clear)  // R17
        else $error("low match flag cleared without read then zero write");

    property p_match_on_leave;
        @(posedge i_clk) disable iff (i_reset)
        (tick_low && equal_low && !wr_cmp_low) |=> status.match_flag_low
            && (counter_low != $past(counter_low) || $past(clear_low && counter_low == 8'h00));
    endproperty
    a_match_on_leave: assert property (p_match_on_leave)  // R25
        else $error("low match not raised as counter left the value");

    property p_match_suppressed;
        @(posedge i_clk) disable iff (i_reset)
        (wr_cmp_low && !status.match_flag_low && !(wr_status && i_wdata[2])) |=> !status.match_flag_low;
    endproperty
    a_match_suppressed: assert property (p_match_suppressed)  // R26
        else $error("match raised during low compare write");

    property p_wide_clear;
        @(posedge i_clk) disable iff (i_reset)
        (match_wide_evt && status.clear_on_match_high && !wr_cnt_high && !wr_cnt_low)
            |=> (counter_high == 8'h00) && (counter_low == 8'h00);
    endproperty
    a_wide_clear: assert property (p_wide_clear)  // R19
        else $error("wide counter not cleared on match");

endmodule // dmt_timer

// file: sim/tb_dmt_timer.sv
`timescale 1ns/10ps
module tb_dmt_timer
    import dmt_pkg::*;
;
    logic        i_clk;
    logic        i_reset;
    logic [3:0]  i_addr;
    logic        i_wr;
    logic        i_rd;
    logic [7:0]  i_wdata;
    logic [7:0]  o_rdata;
    logic        i_event_in_pin;
    logic        i_event_edge_sel;
    logic        o_toggle_out_high;
    logic        o_toggle_out_low;
    logic        o_irq_req_high;
    logic        o_irq_req_low;
    logic        prev_high;
    logic        prev_low;
    logic [31:0] seed;
    logic [7:0]  rv;
    logic [7:0]  rl;
    logic [7:0]  cmp;
    logic [7:0]  cnt_n;
    int          num_errors;
    int          n_checks;
    int          tog_high;
    int          tog_low;
    int          irq_high;
    int          irq_low;

    dmt_timer u_dut (
        .i_clk             (i_clk),
        .i_reset           (i_reset),
        .i_addr            (i_addr),
        .i_wr              (i_wr),
        .i_rd              (i_rd),
        .i_wdata           (i_wdata),
        .o_rdata           (o_rdata),
        .i_event_in_pin    (i_event_in_pin),
        .i_event_edge_sel  (i_event_edge_sel),
        .o_toggle_out_high (o_toggle_out_high),
        .o_toggle_out_low  (o_toggle_out_low),
        .o_irq_req_high    (o_irq_req_high),
        .o_irq_req_low     (o_irq_req_low)
    );

    // System clock, 5 ns period
    initial
    begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    // Toggle edges and interrupt pulses, sampled where settled
    always @(negedge i_clk)
    begin
        if (!i_reset)
        begin
            if (o_toggle_out_high !== prev_high) tog_high++;
            if (o_toggle_out_low !== prev_low) tog_low++;
            if (o_irq_req_high === 1'b1) irq_high++;
            if (o_irq_req_low === 1'b1) irq_low++;
        end
        prev_high <= o_toggle_out_high;
        prev_low  <= o_toggle_out_low;
    end

    // Repeatable pseudo random source
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    // Expected status: low flags over the enable bits
    function automatic logic [7:0] flags(input logic ovf, input logic mat, input logic [7:0] en);
        return en | {4'h0, ovf, mat, 2'b00};
    endfunction

    task automatic cycles(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge i_clk);
        i_wr    = 1'b1;
        i_addr  = a;
        i_wdata = d;
        @(negedge i_clk);
        i_wr = 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(negedge i_clk);
        i_rd   = 1'b1;
        i_addr = a;
        @(negedge i_clk);
        i_rd = 1'b0;
        @(negedge i_clk);
        d = o_rdata;
    endtask

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [7:0] exp, input string nm);
        logic [7:0] d;
        rd(a, d);
        chk(nm, exp, d);
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Watchdog against a hung run
    initial
    begin
        repeat (20000) @(posedge i_clk);
        $display("watchdog expired");
        num_errors++;
        wrap_up();
    end

    initial
    begin
        i_reset          = 1'b1;
        i_addr           = 4'h0;
        i_wr             = 1'b0;
        i_rd             = 1'b0;
        i_wdata          = 8'h00;
        i_event_in_pin   = 1'b0;
        i_event_edge_sel = 1'b1;
        seed             = 32'd54;
        num_errors       = 0;
        n_checks         = 0;
        repeat (16) @(posedge i_clk);
        @(negedge i_clk);
        i_reset = 1'b0;
        // Reset values, refused reads, software cannot set flags
        rdchk(ADDR_COMPARE_VALUE_HIGH, COMPARE_RESET, "cmp_high_reset");
        rdchk(ADDR_COMPARE_VALUE_LOW, COMPARE_RESET, "cmp_low_reset");
        rdchk(ADDR_TIMER_CONTROL, READ_NONE, "ctrl_read");
        rdchk(4'h0, READ_NONE, "unmapped_read");
        wr(ADDR_TIMER_CONTROL_STATUS, STATUS_FLAG_MASK);
        rdchk(ADDR_TIMER_CONTROL_STATUS, STATUS_RESET, "flags_sw_set");
        // Output levels forced by control writes
        wr(ADDR_TIMER_CONTROL, 8'h88);
        chk("tog_high_level", 8'h01, {7'h0, o_toggle_out_high});
        chk("tog_low_level", 8'h01, {7'h0, o_toggle_out_low});
        wr(ADDR_TIMER_CONTROL, CONTROL_RESET);
        chk("tog_high_zero", 8'h00, {7'h0, o_toggle_out_high});
        chk("tog_low_zero", 8'h00, {7'h0, o_toggle_out_low});
        // Low half free run through rollover, then the clearing protocol
        wr(ADDR_TIMER_CONTROL, 8'h40);
        wr(ADDR_COUNTER_LOW, COUNTER_RESET);
        wr(ADDR_TIMER_CONTROL_STATUS, 8'h02);
        irq_low = 0;
        wr(ADDR_TIMER_CONTROL, 8'h47);
        cycles(600);
        wr(ADDR_TIMER_CONTROL, 8'h40);
        chk("irq_low_seen", 8'h01, {7'h0, irq_low > 0});
        wr(ADDR_TIMER_CONTROL_STATUS, 8'h02);
        rdchk(ADDR_TIMER_CONTROL_STATUS, flags(1'b1, 1'b1, 8'h02), "clear_unread");
        wr(ADDR_TIMER_CONTROL_STATUS, 8'h02);
        rdchk(ADDR_TIMER_CONTROL_STATUS, flags(1'b0, 1'b0, 8'h02), "clear_after_read");
        // Low half clear on match with a random compare byte
        seed = xs(seed);
        cmp  = 8'h10 + {2'b00, seed[5:0]};
        wr(ADDR_COMPARE_VALUE_LOW, cmp);
        wr(ADDR_COUNTER_LOW, COUNTER_RESET);
        wr(ADDR_TIMER_CONTROL_STATUS, 8'h01);
        tog_low = 0;
        wr(ADDR_TIMER_CONTROL, 8'h47);
        cycles(240);
        wr(ADDR_TIMER_CONTROL, 8'h40);
        rd(ADDR_COUNTER_LOW, rv);
        chk("cnt_low_bounded", 8'h01, {7'h0, rv <= cmp});
        rdchk(ADDR_TIMER_CONTROL_STATUS, flags(1'b0, 1'b1, 8'h01), "match_low");
        chk("tog_low_seen", 8'h01, {7'h0, tog_low > 0});
        // Event pin counting with a random edge choice
        wr(ADDR_TIMER_CONTROL_STATUS, 8'h00);
        seed             = xs(seed);
        i_event_edge_sel = seed[8];
        cnt_n            = {4'h0, seed[3:0]} + 8'h01;
        wr(ADDR_COUNTER_LOW, COUNTER_RESET);
        repeat (cnt_n)
        begin
            @(negedge i_clk);
            i_event_in_pin = 1'b1;
            cycles(4);
            i_event_in_pin = 1'b0;
            cycles(3);
        end
        cycles(6);
        rdchk(ADDR_COUNTER_LOW, cnt_n, "event_count");
        // High half rollover with overflow interrupt enabled, match at mid count
        wr(ADDR_COMPARE_VALUE_HIGH, 8'h80);
        wr(ADDR_COUNTER_HIGH, COUNTER_RESET);
        wr(ADDR_TIMER_CONTROL_STATUS, 8'h20);
        irq_high = 0;
        wr(ADDR_TIMER_CONTROL, 8'h70);
        cycles(520);
        wr(ADDR_TIMER_CONTROL, 8'h40);
        chk("irq_high_count", 8'h02, irq_high[7:0]);
        rdchk(ADDR_TIMER_CONTROL_STATUS, 8'he0, "ovf_high");
        // Wide mode: paired compare write, full 16-bit match
        seed = xs(seed);
        cmp  = 8'h08 + {4'h0, seed[3:0]};
        wr(ADDR_TIMER_CONTROL, 8'h00);
        wr(ADDR_COMPARE_VALUE_HIGH, 8'h01);
        wr(ADDR_COMPARE_VALUE_LOW, cmp);
        wr(ADDR_COMPARE_VALUE_HIGH, 8'h55);
        rdchk(ADDR_COMPARE_VALUE_HIGH, 8'h01, "cmp_pair_high");
        rdchk(ADDR_COMPARE_VALUE_LOW, cmp, "cmp_pair_low");
        wr(ADDR_COUNTER_HIGH, 8'h00);
        wr(ADDR_COUNTER_LOW, 8'h00);
        wr(ADDR_TIMER_CONTROL_STATUS, 8'h10);
        tog_high = 0;
        irq_high = 0;
        wr(ADDR_TIMER_CONTROL, 8'h07);
        cycles(60);
        rd(ADDR_TIMER_CONTROL_STATUS, rv);
        chk("wide_early", 8'h00, {7'h0, rv[6]});
        cycles(700);
        wr(ADDR_TIMER_CONTROL, 8'h00);
        rd(ADDR_TIMER_CONTROL_STATUS, rv);
        chk("wide_match", 8'h01, {7'h0, rv[6]});
        chk("wide_no_ovf", 8'h00, {7'h0, rv[7]});
        chk("tog_high_seen", 8'h01, {7'h0, tog_high > 0});
        chk("irq_high_seen", 8'h01, {7'h0, irq_high > 0});
        rd(ADDR_COUNTER_HIGH, rv);
        rd(ADDR_COUNTER_LOW, rl);
        chk("wide_bounded", 8'h01, {7'h0, {rv, rl} <= {8'h01, cmp}});
        wrap_up();
    end
endmodule // tb_dmt_timer
